//--- vsn_consts.svh
`ifndef VSN_CONSTS_SVH
`define VSN_CONSTS_SVH
// ==========================================
// register map (word index on the plain port)
`define VSN_A_GAIN_MODE   6'h00
`define VSN_A_TUNE_MODE   6'h01
`define VSN_A_FUNC_SEL    6'h02
`define VSN_A_MODEL_GAIN  6'h03
`define VSN_A_NOTCH       6'h04
`define VSN_A_GSW_SEL     6'h05
`define VSN_A_GSW_THR     6'h06
`define VSN_A_STATUS      6'h07
`define VSN_A_NOTCH_ACT   6'h08
`define VSN_A_BANK_BASE   6'h10
`define VSN_A_BANK_LAST   6'h1F
// ==========================================
// field values
`define VSN_GM_AUTO2      4'h2
`define VSN_GM_MANUAL     4'h3
`define VSN_GM_TWO_GAIN2  4'h4
`define VSN_FSEL_VSC2     4'h1
`define VSN_NOTCH_LAST    7'h5F
`define VSN_NOTCH_OFF     7'h00
`define VSN_DEPTH_FULL    3'h4
// ==========================================
// frequency limits, 0.1 Hz units
`define VSN_TUNE_MIN      16'h000A
`define VSN_TUNE_MAX      16'h03E8
// 0.9/(2*pi) in 0.1 Hz per gain unit, q10
`define VSN_C1_MUL        12'h5BB
`define VSN_C1_SHIFT      10
`define VSN_C2_OFFS       16'h0032
`define VSN_RATIO_LO      5'h0B
`define VSN_RATIO_LO_DIV  5'h0A
`define VSN_RATIO_HI_DIV  5'h02
// ==========================================
// timing
`define VSN_CLK_HZ        25000000
`define VSN_NOTCH_DLY_MS  150
`define VSN_NOTCH_DLY_CYC (`VSN_NOTCH_DLY_MS * (`VSN_CLK_HZ / 1000))
`define VSN_POS_OPS       10
// ==========================================
// notch stage, 20 kHz command rate: 2*pi*f/fs q16 per 0.1 Hz, q8
`define VSN_SVF_K         10'h20F
`define VSN_SVF_KSH       8
`define VSN_SVF_FSH       16
`define VSN_DEPTH_SH      2
`define VSN_FIFO_DEPTH    8
`endif

//--- vsn_pkg.sv
package vsn_pkg;
   // ==========================================
   // tuning mode digit
   typedef enum logic [3:0] {
      VSN_TM_OFF    = 4'h0,
      VSN_TM_AUTO   = 4'h1,
      VSN_TM_MANUAL = 4'h2
   } vsn_tune_e;
   // gain switching condition
   typedef enum logic [3:0] {
      VSN_GS_NONE  = 4'h0,
      VSN_GS_INPUT = 4'h1,
      VSN_GS_CMDF  = 4'h2,
      VSN_GS_DROOP = 4'h3,
      VSN_GS_SPEED = 4'h4
   } vsn_gsw_e;
   typedef struct packed {
      logic [15:0] vib_freq;
      logic [15:0] res_freq;
      logic [15:0] vib_damp;
      logic [15:0] res_damp;
   } vsn_vsc_s;
   typedef struct packed {
      logic [1:0]  depth;
      logic [6:0]  code;
   } vsn_notch_s;
endpackage : vsn_pkg

//--- vsn_ctrl.sv
`timescale 1ns/1ps
`include "vsn_consts.svh"

module vsn_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [0:D-1];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0]   cnt_ff;
   logic          push;
   logic          pop;

   assign in_ready_o  = (cnt_ff != (AW+1)'(D));
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o  = mem[rp_ff];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wp_ff <= (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
         end
         if (pop) begin
            rp_ff <= (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : vsn_fifo

module vsn_ctrl #(
   parameter int NOTCH_DLY_CYC = `VSN_NOTCH_DLY_CYC,
   parameter int POS_OPS       = `VSN_POS_OPS
) (
   // clock and reset
   input  wire logic            REF_CLK_I,
   input  wire logic            SYS_RST_I,
   // register port
   input  wire logic [5:0]      REG_ADDR_I,
   input  wire logic [15:0]     REG_WDATA_I,
   input  wire logic            REG_WR_I,
   input  wire logic            REG_RD_I,
   output logic [15:0]          REG_RDATA_O,
   // motor loop state
   input  wire logic            MOTOR_STOP_I,
   input  wire logic            POS_DONE_I,
   input  wire logic            GAIN_SW_IN_I,
   input  wire logic [15:0]     CMD_FREQ_I,
   input  wire logic [15:0]     DROOP_I,
   input  wire logic [15:0]     SPEED_I,
   // vibration estimator
   input  wire logic            EST_VALID_I,
   input  wire logic            EST_CTRL_I,
   input  wire vsn_pkg::vsn_vsc_s EST_I,
   // position command in
   input  wire logic            CMD_VALID_I,
   output logic                 CMD_READY_O,
   input  wire logic [15:0]     CMD_DATA_I,
   // position command out
   output logic                 POS_VALID_O,
   input  wire logic            POS_READY_I,
   output logic [15:0]          POS_DATA_O,
   // active suppression settings
   output vsn_pkg::vsn_vsc_s    VSC1_O,
   output vsn_pkg::vsn_vsc_s    VSC2_O,
   output logic                 VSC1_EN_O,
   output logic                 VSC2_EN_O,
   output logic                 GAIN_SW_O
);
   localparam logic [15:0] NOTCH_TBL [0:95] = '{
      16'h0000, 16'h57E4, 16'h2BF2, 16'h1D4C, 16'h15F4, 16'h1194,
      16'h0EA6, 16'h0C8A, 16'h0AFA, 16'h09C4, 16'h08CA, 16'h07F8,
      16'h074E, 16'h06C2, 16'h0640, 16'h05DC, 16'h0578, 16'h0528,
      16'h04E2, 16'h049C, 16'h0460, 16'h042E, 16'h03FC, 16'h03CA,
      16'h03A2, 16'h0384, 16'h035C, 16'h033E, 16'h0320, 16'h0302,
      16'h02EE, 16'h02D0, 16'h02BC, 16'h0294, 16'h026C, 16'h024E,
      16'h0230, 16'h0212, 16'h01FE, 16'h01E0, 16'h01CC, 16'h01C2,
      16'h01AE, 16'h019A, 16'h0190, 16'h017C, 16'h0172, 16'h0168,
      16'h0160, 16'h014B, 16'h0139, 16'h0128, 16'h0119, 16'h010C,
      16'h0100, 16'h00F5, 16'h00EA, 16'h00E1, 16'h00D8, 16'h00D0,
      16'h00C9, 16'h00C2, 16'h00BC, 16'h00B6, 16'h00B0, 16'h00A5,
      16'h009C, 16'h0094, 16'h008D, 16'h0086, 16'h0080, 16'h007A,
      16'h0075, 16'h0071, 16'h006C, 16'h0068, 16'h0064, 16'h0061,
      16'h005E, 16'h005B, 16'h0058, 16'h0053, 16'h004E, 16'h004A,
      16'h0046, 16'h0043, 16'h0040, 16'h003D, 16'h003B, 16'h0038,
      16'h0036, 16'h0034, 16'h0032, 16'h0031, 16'h002F, 16'h002D
   };

   // ==========================================
   // parameter registers
   logic [3:0]          gain_adjust_mode_param_ff;
   logic [7:0]          vsc_tuning_mode_param_ff;
   logic [3:0]          function_select_param_ff;
   logic [15:0]         model_loop_gain_param_ff;
   vsn_pkg::vsn_notch_s cmd_notch_setting_ff;
   vsn_pkg::vsn_notch_s notch_act_ff;
   logic [3:0]          gain_switch_selection_ff;
   logic [15:0]         gain_switch_threshold_ff;
   // two banks of eight words: before and after gain switching
   logic [15:0]         bank_ff [0:15];
   logic [15:0]         rdata_ff;
   logic [7:0]          ops_ff;
   logic [21:0]         stop_cnt_ff;
   logic                gsw_ff;
   logic                wr_hit;
   logic                vsc_ok;
   logic                tune1_auto;
   logic                tune2_auto;
   logic                est_ok;
   logic                ops_done;
   logic                fs_ok;

   assign wr_hit   = REG_WR_I;
   assign vsc_ok   = (gain_adjust_mode_param_ff == `VSN_GM_AUTO2)
                   | (gain_adjust_mode_param_ff == `VSN_GM_MANUAL)
                   | (gain_adjust_mode_param_ff == `VSN_GM_TWO_GAIN2);
   assign tune1_auto = vsc_tuning_mode_param_ff[3:0]
                       == vsn_pkg::VSN_TM_AUTO;
   assign tune2_auto = vsc_tuning_mode_param_ff[7:4]
                       == vsn_pkg::VSN_TM_AUTO;
   // estimates outside the band are dropped; user sets those by hand
   assign est_ok   = EST_VALID_I & vsc_ok
                   & (EST_I.vib_freq >= `VSN_TUNE_MIN)
                   & (EST_I.vib_freq <= `VSN_TUNE_MAX)
                   & (EST_I.res_freq >= `VSN_TUNE_MIN)
                   & (EST_I.res_freq <= `VSN_TUNE_MAX);
   assign ops_done = POS_DONE_I & (ops_ff == 8'(POS_OPS - 1));
   assign fs_ok    = function_select_param_ff == `VSN_FSEL_VSC2;

   // ==========================================
   // software registers
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         gain_adjust_mode_param_ff <= 4'h1;
         function_select_param_ff  <= 4'h0;
         model_loop_gain_param_ff  <= 16'h0000;
         cmd_notch_setting_ff      <= '0;
         gain_switch_selection_ff  <= 4'h0;
         gain_switch_threshold_ff  <= 16'h0000;
      end else if (wr_hit) begin
         case (REG_ADDR_I)
            `VSN_A_GAIN_MODE:
               gain_adjust_mode_param_ff <= REG_WDATA_I[3:0];
            `VSN_A_FUNC_SEL:
               function_select_param_ff <= REG_WDATA_I[3:0];
            `VSN_A_MODEL_GAIN: model_loop_gain_param_ff <= REG_WDATA_I;
            `VSN_A_NOTCH: cmd_notch_setting_ff <= REG_WDATA_I[8:0];
            `VSN_A_GSW_SEL:
               gain_switch_selection_ff <= REG_WDATA_I[3:0];
            `VSN_A_GSW_THR: gain_switch_threshold_ff <= REG_WDATA_I;
            default: ;
         endcase
      end
   end

   // tuning mode: hardware hand-over to manual wins over a write
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         vsc_tuning_mode_param_ff <= 8'h00;
      end else if (ops_done & (tune1_auto | tune2_auto)) begin
         if (tune1_auto) begin
            vsc_tuning_mode_param_ff[3:0] <= vsn_pkg::VSN_TM_MANUAL;
         end
         if (tune2_auto) begin
            vsc_tuning_mode_param_ff[7:4] <= vsn_pkg::VSN_TM_MANUAL;
         end
      end else if (wr_hit & (REG_ADDR_I == `VSN_A_TUNE_MODE)) begin
         vsc_tuning_mode_param_ff <= REG_WDATA_I[7:0];
      end
   end

   // positioning operations counted only while any control auto-tunes
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         ops_ff <= 8'h00;
      end else if (!(tune1_auto | tune2_auto) | ops_done) begin
         ops_ff <= 8'h00;
      end else if (POS_DONE_I) begin
         ops_ff <= ops_ff + 8'h01;
      end
   end

   // settings banks: words 0-3 control 1, 4-7 control 2
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         for (int i = 0; i < 16; i++) begin
            bank_ff[i] <= 16'h0000;
         end
      end else begin
         if (wr_hit & (REG_ADDR_I >= `VSN_A_BANK_BASE)
             & (REG_ADDR_I <= `VSN_A_BANK_LAST)) begin
            bank_ff[REG_ADDR_I[3:0]] <= REG_WDATA_I;
         end
         // estimates land in the before-switch bank
         if (est_ok & !EST_CTRL_I & tune1_auto) begin
            {bank_ff[0], bank_ff[1], bank_ff[2], bank_ff[3]} <= EST_I;
         end
         if (est_ok & EST_CTRL_I & tune2_auto) begin
            {bank_ff[4], bank_ff[5], bank_ff[6], bank_ff[7]} <= EST_I;
         end
      end
   end

   // ==========================================
   // gain switching
   logic gsw_nxt;
   always_comb begin
      gsw_nxt = 1'b0;
      case (vsn_pkg::vsn_gsw_e'(gain_switch_selection_ff))
         vsn_pkg::VSN_GS_INPUT: gsw_nxt = GAIN_SW_IN_I;
         vsn_pkg::VSN_GS_CMDF:
            gsw_nxt = CMD_FREQ_I >= gain_switch_threshold_ff;
         vsn_pkg::VSN_GS_DROOP:
            gsw_nxt = DROOP_I >= gain_switch_threshold_ff;
         vsn_pkg::VSN_GS_SPEED:
            gsw_nxt = SPEED_I >= gain_switch_threshold_ff;
         default: gsw_nxt = 1'b0;
      endcase
      if (gain_adjust_mode_param_ff != `VSN_GM_MANUAL) begin
         gsw_nxt = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         gsw_ff <= 1'b0;
      end else begin
         gsw_ff <= gsw_nxt;
      end
   end

   // ==========================================
   // effectiveness of each control
   vsn_pkg::vsn_vsc_s act1;
   vsn_pkg::vsn_vsc_s act2;
   logic [27:0]       lim1;
   logic [16:0]       lim2;
   logic [20:0]       f1_x11;
   logic [20:0]       f2_x10;
   logic [20:0]       f2_x2;
   logic              eff1;
   logic              eff2;

   // gain switching picks the after-switch bank
   assign act1 = gsw_ff ? {bank_ff[8], bank_ff[9], bank_ff[10], bank_ff[11]}
                        : {bank_ff[0], bank_ff[1], bank_ff[2], bank_ff[3]};
   assign act2 = gsw_ff ? {bank_ff[12], bank_ff[13], bank_ff[14], bank_ff[15]}
                        : {bank_ff[4], bank_ff[5], bank_ff[6], bank_ff[7]};
   assign lim1 = (28'(model_loop_gain_param_ff) * 28'(`VSN_C1_MUL))
                 >> `VSN_C1_SHIFT;
   assign lim2 = 17'(model_loop_gain_param_ff) + 17'(`VSN_C2_OFFS);
   assign f1_x11 = 21'(act1.vib_freq) * 21'(`VSN_RATIO_LO);
   assign f2_x10 = 21'(act2.vib_freq) * 21'(`VSN_RATIO_LO_DIV);
   assign f2_x2  = 21'(act2.vib_freq) * 21'(`VSN_RATIO_HI_DIV);
   assign eff1 = vsc_ok
               & (vsc_tuning_mode_param_ff[3:0] != vsn_pkg::VSN_TM_OFF)
               & (28'(act1.vib_freq) >= lim1)
               & (28'(act1.res_freq) >= lim1);
   // ratio 1.1 < f2/f1 < 5.5 kept as 10*f2 > 11*f1 and 2*f2 < 11*f1
   assign eff2 = vsc_ok & fs_ok
               & (vsc_tuning_mode_param_ff[7:4] != vsn_pkg::VSN_TM_OFF)
               & (17'(act2.vib_freq) >= lim2)
               & (17'(act2.res_freq) >= lim2)
               & (f2_x10 > f1_x11) & (f2_x2 < f1_x11);

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         VSC1_O    <= '0;
         VSC2_O    <= '0;
         VSC1_EN_O <= 1'b0;
         VSC2_EN_O <= 1'b0;
      end else begin
         VSC1_O    <= act1;
         VSC2_O    <= act2;
         VSC1_EN_O <= eff1;
         VSC2_EN_O <= eff2;
      end
   end

   assign GAIN_SW_O = gsw_ff;

   // ==========================================
   // notch setting applied only after a settled stop
   // a write while stopped restarts the wait, so no mid-move step
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         stop_cnt_ff  <= '0;
         notch_act_ff <= '0;
      end else if (!MOTOR_STOP_I
                   | (wr_hit & (REG_ADDR_I == `VSN_A_NOTCH))) begin
         stop_cnt_ff <= '0;
      end else if (stop_cnt_ff == 22'(NOTCH_DLY_CYC - 1)) begin
         notch_act_ff <= cmd_notch_setting_ff;
      end else begin
         stop_cnt_ff <= stop_cnt_ff + 22'h1;
      end
   end

   // ==========================================
   // command path: fifo then state-variable notch
   logic               fifo_valid;
   logic [15:0]        fifo_data;
   logic               take;
   logic               notch_on;
   logic [15:0]        fc;
   logic [17:0]        fk;
   logic signed [23:0] lp_ff;
   logic signed [23:0] bp_ff;
   logic signed [23:0] x;
   logic signed [23:0] hp;
   logic signed [41:0] dbp;
   logic signed [41:0] dlp;
   logic signed [23:0] y;
   logic signed [23:0] y_sat;

   vsn_fifo #(
      .W (16),
      .D (`VSN_FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (REF_CLK_I),
      .rst_i       (SYS_RST_I),
      .in_valid_i  (CMD_VALID_I),
      .in_ready_o  (CMD_READY_O),
      .in_data_i   (CMD_DATA_I),
      .out_valid_o (fifo_valid),
      .out_ready_i (take),
      .out_data_o  (fifo_data)
   );

   assign take = fifo_valid & (!POS_VALID_O | POS_READY_I);
   // codes past the table are treated as off
   assign notch_on = (notch_act_ff.code != `VSN_NOTCH_OFF)
                   & (notch_act_ff.code <= `VSN_NOTCH_LAST);
   assign fc  = notch_on ? NOTCH_TBL[notch_act_ff.code] : 16'h0000;
   assign fk  = 18'((28'(fc) * 28'(`VSN_SVF_K)) >> `VSN_SVF_KSH);
   assign x   = 24'(signed'(fifo_data));
   assign hp  = x - lp_ff - bp_ff;
   assign dbp = ($signed({24'h00_0000, fk}) * 42'(hp)) >>> `VSN_SVF_FSH;
   assign dlp = ($signed({24'h00_0000, fk}) * 42'(bp_ff)) >>> `VSN_SVF_FSH;
   // depth 0 is the deepest cut, 3 the shallowest
   assign y   = x - ((bp_ff * $signed(24'(`VSN_DEPTH_FULL
                     - {1'b0, notch_act_ff.depth})))
                     >>> `VSN_DEPTH_SH);
   assign y_sat = (y > 24'sh00_7FFF) ? 24'sh00_7FFF
                : (y < -24'sh00_8000) ? -24'sh00_8000 : y;

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I | !notch_on) begin
         lp_ff <= '0;
         bp_ff <= '0;
      end else if (take) begin
         bp_ff <= bp_ff + 24'(dbp);
         lp_ff <= lp_ff + 24'(dlp);
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         POS_VALID_O <= 1'b0;
         POS_DATA_O  <= 16'h0000;
      end else if (take) begin
         POS_VALID_O <= 1'b1;
         POS_DATA_O  <= notch_on ? y_sat[15:0] : fifo_data;
      end else if (POS_READY_I) begin
         POS_VALID_O <= 1'b0;
      end
   end

   // ==========================================
   // read port, data in the cycle after the strobe
   logic [15:0] rd_nxt;
   always_comb begin
      rd_nxt = 16'h0000;
      case (REG_ADDR_I)
         `VSN_A_GAIN_MODE: rd_nxt = {12'h000, gain_adjust_mode_param_ff};
         `VSN_A_TUNE_MODE: rd_nxt = {8'h00, vsc_tuning_mode_param_ff};
         `VSN_A_FUNC_SEL:  rd_nxt = {12'h000, function_select_param_ff};
         `VSN_A_MODEL_GAIN: rd_nxt = model_loop_gain_param_ff;
         `VSN_A_NOTCH:     rd_nxt = {7'h00, cmd_notch_setting_ff};
         `VSN_A_GSW_SEL:   rd_nxt = {12'h000, gain_switch_selection_ff};
         `VSN_A_GSW_THR:   rd_nxt = gain_switch_threshold_ff;
         `VSN_A_STATUS:    rd_nxt = {ops_ff, 2'b00,
                                     notch_act_ff != cmd_notch_setting_ff,
                                     notch_on, gsw_ff, VSC2_EN_O,
                                     VSC1_EN_O, vsc_ok};
         `VSN_A_NOTCH_ACT: rd_nxt = {7'h00, notch_act_ff};
         default: begin
            if (REG_ADDR_I >= `VSN_A_BANK_BASE) begin
               if (REG_ADDR_I <= `VSN_A_BANK_LAST) begin
                  rd_nxt = bank_ff[REG_ADDR_I[3:0]];
               end
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         rdata_ff <= 16'h0000;
      end else if (REG_RD_I) begin
         rdata_ff <= rd_nxt;
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign REG_RDATA_O = rdata_ff;
endmodule : vsn_ctrl

//--- vsn_ctrl_asserts.sv
`timescale 1ns/1ps
// ==========================================
// checker on the control block ports
module vsn_ctrl_asserts (
   // clock and reset
   input  wire logic              REF_CLK_I,
   input  wire logic              SYS_RST_I,
   // register port
   input  wire logic [5:0]        REG_ADDR_I,
   input  wire logic [15:0]       REG_WDATA_I,
   input  wire logic              REG_WR_I,
   // loop input and command out
   input  wire logic              GAIN_SW_IN_I,
   input  wire logic              POS_VALID_O,
   input  wire logic              POS_READY_I,
   input  wire logic [15:0]       POS_DATA_O,
   // suppression outputs
   input  wire vsn_pkg::vsn_vsc_s VSC1_O,
   input  wire vsn_pkg::vsn_vsc_s VSC2_O,
   input  wire logic              VSC1_EN_O,
   input  wire logic              VSC2_EN_O,
   input  wire logic              GAIN_SW_O
);
   logic [15:0] gm_ff, tm_ff, fs_ff, mg_ff, sel_ff;
   // shadow copies of the settings, so no peek inside is needed
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         gm_ff  <= 16'h0001;
         tm_ff  <= 16'h0000;
         fs_ff  <= 16'h0000;
         mg_ff  <= 16'h0000;
         sel_ff <= 16'h0000;
      end else if (REG_WR_I) begin
         if (REG_ADDR_I == 6'h00) gm_ff <= REG_WDATA_I;
         if (REG_ADDR_I == 6'h01) tm_ff <= REG_WDATA_I;
         if (REG_ADDR_I == 6'h02) fs_ff <= REG_WDATA_I;
         if (REG_ADDR_I == 6'h03) mg_ff <= REG_WDATA_I;
         if (REG_ADDR_I == 6'h05) sel_ff <= REG_WDATA_I;
      end
   end
   wire allow = gm_ff[3:0] inside {4'h2, 4'h3, 4'h4};
   wire gm3   = gm_ff[3:0] == 4'h3;
   wire sel1  = sel_ff[3:0] == 4'h1;
   wire t1_on = tm_ff[3:0] != 4'h0;
   wire t2_on = tm_ff[7:4] != 4'h0;
   wire fs1   = fs_ff[3:0] == 4'h1;
   wire [31:0] lim1 = 32'(mg_ff) * 32'd1467;
   wire [31:0] f1   = 32'(VSC1_O.vib_freq);
   wire [31:0] f2   = 32'(VSC2_O.vib_freq);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence stall_s;
      POS_VALID_O && !POS_READY_I;
   endsequence
   allow_gate_a: assert property (
      (VSC1_EN_O || VSC2_EN_O) |-> $past(allow))
      else $error("suppression active in a barred gain mode");
   tune1_on_a: assert property (VSC1_EN_O |-> $past(t1_on))
      else $error("control 1 active while disabled");
   tune2_on_a: assert property (VSC2_EN_O |-> $past(t2_on))
      else $error("control 2 active while disabled");
   fsel_need_a: assert property (VSC2_EN_O |-> $past(fs1))
      else $error("control 2 active without function select");
   c1_limit_a: assert property (
      VSC1_EN_O |-> (f1 << 10) >= $past(lim1))
      else $error("control 1 active below its limit");
   c2_ratio_a: assert property (
      VSC2_EN_O |-> 10 * f2 > 11 * f1 && 2 * f2 < 11 * f1)
      else $error("control 2 active outside its ratio");
   gsw_manual_a: assert property (GAIN_SW_O |-> $past(gm3))
      else $error("gain switched outside manual mode");
   gsw_input_a: assert property (
      $past(gm3) && $past(sel1) |-> GAIN_SW_O == $past(GAIN_SW_IN_I))
      else $error("gain switch does not follow its input");
   stall_hold_a: assert property (
      stall_s |=> POS_VALID_O && $stable(POS_DATA_O))
      else $error("command word dropped while stalled");
endmodule : vsn_ctrl_asserts

bind vsn_ctrl vsn_ctrl_asserts i_chk (.REF_CLK_I, .SYS_RST_I,
   .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .GAIN_SW_IN_I, .POS_VALID_O,
   .POS_READY_I, .POS_DATA_O, .VSC1_O, .VSC2_O, .VSC1_EN_O,
   .VSC2_EN_O, .GAIN_SW_O);

//--- vsn_cmd_sink.sv
`timescale 1ns/1ps
// ==========================================
// motor loop end of the command stream
module vsn_cmd_sink (
   // clock
   input  wire logic        clk_i,
   // stream from the block
   input  wire logic        valid_i,
   input  wire logic [15:0] data_i,
   output logic             ready_o,
   // test control
   input  wire logic        stall_i
);
   logic [15:0] got[$];
   // back pressure only: the block must hold its word while stalled
   assign ready_o = !stall_i;
   always @(posedge clk_i) begin
      if (valid_i && ready_o) got.push_back(data_i);
   end
endmodule : vsn_cmd_sink

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 0, rst = 1, wr = 0, rd = 0, mstop = 1, pdone = 0;
   logic gsw_in = 0, est_v = 0, est_c = 0, cvalid = 0, stall = 0;
   logic cready, pvalid, pready, en1, en2, gsw, ok;
   logic [5:0]  addr = 0;
   logic [15:0] wdata = 0, cfreq = 0, droop = 0, speed = 0, cdata = 0;
   logic [15:0] rdata, pdata;
   vsn_pkg::vsn_vsc_s est = '0;
   vsn_pkg::vsn_vsc_s vsc1, vsc2;
   int failures = 0, compares = 0, k, n;
   // ==========================================
   // design and far side
   vsn_ctrl #(.NOTCH_DLY_CYC(20), .POS_OPS(3)) i_dut (.REF_CLK_I(clk),
      .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
      .MOTOR_STOP_I(mstop), .POS_DONE_I(pdone), .GAIN_SW_IN_I(gsw_in),
      .CMD_FREQ_I(cfreq), .DROOP_I(droop), .SPEED_I(speed),
      .EST_VALID_I(est_v), .EST_CTRL_I(est_c), .EST_I(est),
      .CMD_VALID_I(cvalid), .CMD_READY_O(cready), .CMD_DATA_I(cdata),
      .POS_VALID_O(pvalid), .POS_READY_I(pready), .POS_DATA_O(pdata),
      .VSC1_O(vsc1), .VSC2_O(vsc2), .VSC1_EN_O(en1), .VSC2_EN_O(en2),
      .GAIN_SW_O(gsw));
   vsn_cmd_sink i_sink (.clk_i(clk), .valid_i(pvalid), .data_i(pdata),
      .ready_o(pready), .stall_i(stall));
   initial forever #20 clk = ~clk;
   // ==========================================
   // access tasks
   task chk(input logic [63:0] s, input logic [63:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task cyc(input int c);
      repeat (c) @(posedge clk);
   endtask : cyc
   task wr_reg(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      wr    <= 1'h1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'h0;
   endtask : wr_reg
   task rd_chk(input logic [5:0] a, input logic [15:0] e);
      @(posedge clk);
      rd   <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'h0;
      #1 chk(rdata, e);
   endtask : rd_chk
   task bank(input logic [5:0] b, input logic [15:0] f);
      for (int i = 0; i < 4; i++) wr_reg(b + 6'(i), i < 2 ? f : 16'h0005);
   endtask : bank
   task push(input logic [15:0] d);
      @(posedge clk);
      cvalid <= 1'h1;
      cdata  <= d;
      ok = 0;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk);
         ok = cready === 1'h1;
      end
      cvalid <= 1'h0;
   endtask : push
   task est_put(input logic c, input logic [15:0] f);
      @(posedge clk);
      est_v <= 1'h1;
      est_c <= c;
      est   <= {f, f, 16'h0003, 16'h0004};
      @(posedge clk);
      est_v <= 1'h0;
   endtask : est_put
   task complete_run;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      repeat (6000) @(posedge clk);
      failures++;
      complete_run();
   end
   // ==========================================
   // scenarios, motor held stopped while settings change, except around the first notch write
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      rd_chk(6'h00, 16'h0001);
      rd_chk(6'h01, 16'h0000);
      wr_reg(6'h3F, 16'hFFFF);
      rd_chk(6'h3F, 16'h0000);
      @(posedge clk);
      stall <= 1'h1;
      for (n = 0; n < 16; n++) begin
         push(16'h0A00 + 16'(n));
         if (!ok) break;
      end
      chk(cready, 0);
      chk(n >= 8, 1);
      @(posedge clk);
      stall <= 1'h0;
      cyc(30);
      chk(i_sink.got.size(), n);
      for (k = 0; k < n; k++) chk(i_sink.got[k], 16'h0A00 + 16'(k));
      wr_reg(6'h00, 16'h0003);
      wr_reg(6'h01, 16'h0022);
      wr_reg(6'h02, 16'h0001);
      wr_reg(6'h03, 16'h0010);
      bank(6'h10, 16'h0100);
      bank(6'h14, 16'h0200);
      cyc(3);
      chk(vsc1, {16'h0100, 16'h0100, 16'h0005, 16'h0005});
      chk(vsc2, {16'h0200, 16'h0200, 16'h0005, 16'h0005});
      chk(en2, 1);
      for (k = 0; k < 6; k++) begin
         wr_reg(6'h00, 16'(k));
         cyc(3);
         chk(en1, k inside {2, 3, 4});
      end
      wr_reg(6'h00, 16'h0003);
      for (k = 0; k < 3; k++) begin
         wr_reg(6'h01, 16'h0020 | 16'(k));
         cyc(3);
         chk(en1, k != 0);
         wr_reg(6'h01, 16'h0002 | 16'(k << 4));
         cyc(3);
         chk(en2, k != 0);
      end
      wr_reg(6'h02, 16'h0000);
      cyc(3);
      chk(en2, 0);
      wr_reg(6'h02, 16'h0001);
      wr_reg(6'h14, 16'h0110);
      cyc(3);
      chk(en2, 0);
      wr_reg(6'h14, 16'h0200);
      wr_reg(6'h03, 16'h00C0);
      cyc(3);
      chk(en1, 0);
      wr_reg(6'h03, 16'h0010);
      bank(6'h18, 16'h0120);
      wr_reg(6'h06, 16'h0010);
      @(posedge clk);
      {gsw_in, cfreq, droop, speed} <= {1'h1, 48'hFFFF_FFFF_FFFF};
      for (k = 0; k < 5; k++) begin
         wr_reg(6'h05, 16'(k));
         cyc(3);
         chk(gsw, k != 0);
      end
      chk(vsc1, {16'h0120, 16'h0120, 16'h0005, 16'h0005});
      wr_reg(6'h00, 16'h0002);
      cyc(3);
      chk(gsw, 0);
      wr_reg(6'h01, 16'h0011);
      est_put(1'h0, 16'h0200);
      rd_chk(6'h10, 16'h0200);
      est_put(1'h0, 16'h03E8);
      rd_chk(6'h10, 16'h03E8);
      est_put(1'h1, 16'h0500);
      rd_chk(6'h14, 16'h0200);
      est_put(1'h1, 16'h0300);
      rd_chk(6'h14, 16'h0300);
      for (k = 0; k < 3; k++) begin
         if (k == 2) rd_chk(6'h01, 16'h0011);
         @(posedge clk);
         pdone <= 1'h1;
         @(posedge clk);
         pdone <= 1'h0;
      end
      cyc(2);
      rd_chk(6'h01, 16'h0022);
      @(posedge clk);
      mstop <= 1'h0;
      wr_reg(6'h04, 16'h0105);
      cyc(30);
      rd_chk(6'h08, 16'h0000);
      @(posedge clk);
      mstop <= 1'h1;
      cyc(10);
      rd_chk(6'h08, 16'h0000);
      cyc(15);
      rd_chk(6'h08, 16'h0105);
      rd_chk(6'h07, 16'h0013);
      wr_reg(6'h04, 16'h0060);
      cyc(40);
      n = i_sink.got.size();
      push(16'h1234);
      cyc(10);
      chk(i_sink.got[n], 16'h1234);
      complete_run();
   end
endmodule : testbench
